// >>> inc/mut_defines.vh
// constants for the modulo up timer
// Notes on behaviour
// - count register shows live count; writes to it are ignored
// - wrap limit zero means free run over full 8-bit range
// - any wrap limit write zeroes count and clears overflow flag, unless a wrap sets it in that cycle
// - reset: halted, count zero, limit zero, bus clock, divide by one
// - nonzero wrap limit while running gives modulo mode
// - source: bus clock, fixed-rate clock, tick pin rising or falling
// - source change while running keeps count
// - prescaler divides by 1 to 256 in powers of two
// - divide ratio change while running keeps count
// - wrap limit accepts any value 0x01 to 0xff
// - count up to limit, then roll to zero and continue
// - overflow flag sets on step from limit to zero
// - flag clears by status read while set, then writing zero
// - overflow between read and write cancels the clear
// - writing one to counter clear bit also clears flag, unless a wrap sets it in that cycle
// - interrupt request while flag set and enable is one
// - counter clear bit write-only, one zeroes count, reads zero
// - halt bit freezes count, clearing resumes; reset sets it
// - source codes: 00 bus, 01 fixed, 10 falling, 11 rising
// - divider codes 0 to 8 give 2**code; higher codes give 256
`ifndef MUT_DEFINES_VH
`define MUT_DEFINES_VH
`define MUT_ADDR_CTRL 12'h000
`define MUT_ADDR_CLK 12'h004
`define MUT_ADDR_TALLY 12'h008
`define MUT_ADDR_LIMIT 12'h00c
`define MUT_BIT_FLAG 7
`define MUT_BIT_IEN 6
`define MUT_BIT_CLR 5
`define MUT_BIT_HALT 4
`define MUT_SRC_LSB 4
`define MUT_SRC_MSB 5
`define MUT_DIV_MSB 3
`define MUT_SRC_BUS 2'h0
`define MUT_SRC_FIXED 2'h1
`define MUT_SRC_FALL 2'h2
`define MUT_SRC_RISE 2'h3
`define MUT_DIV_MAX 4'h8
`define MUT_ZERO8 8'h00
`define MUT_ONES8 8'hff
`endif

// >>> core/mut_edge_sync.v
// tick pin synchroniser and edge detector
`timescale 1ns/100ps
`default_nettype none
module mut_edge_sync (
  input wire clock,
  input wire rst_n,
  input wire pin,
  output reg rise,
  output reg fall
);
  reg meta;
  reg sync;
  reg last;
  // stages follow the pin through reset, so no false edge after it
  always @(posedge clock) begin
    meta <= pin;
    sync <= meta;
    last <= sync;
  end
  always @(posedge clock) begin
    if (!rst_n) begin
      rise <= 1'b0;
      fall <= 1'b0;
    end else begin
      rise <= sync & ~last;
      fall <= ~sync & last;
    end
  end
endmodule
`default_nettype wire

// >>> core/mut_prescaler.v
// nine-step power-of-two prescaler
`timescale 1ns/100ps
`default_nettype none
`include "mut_defines.vh"
module mut_prescaler (
  input wire clock,
  input wire rst_n,
  input wire src_tick,
  input wire [3:0] divider_select,
  output reg step
);
  reg [7:0] div_count;
  reg [7:0] mask;
  always @* begin
    if (divider_select > `MUT_DIV_MAX) begin
      mask = `MUT_ONES8;
    end else begin
      mask = (8'h01 << divider_select[2:0]) - 8'h01;
      if (divider_select[3]) begin
        mask = `MUT_ONES8;
      end
    end
  end
  // divider keeps running across ratio changes, count is untouched
  always @(posedge clock) begin
    if (!rst_n) begin
      div_count <= `MUT_ZERO8;
      step <= 1'b0;
    end else begin
      step <= src_tick && ((div_count & mask) == mask);
      if (src_tick) begin
        div_count <= div_count + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// >>> core/mut_timer.v
// modulo up timer with apb register access
`timescale 1ns/100ps
`default_nettype none
`include "mut_defines.vh"
module mut_timer (
  input wire clock,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire fixed_rate_clock,
  input wire external_tick_pin,
  output reg overflow_irq
);
  //////////////////////////////////////////////////////////////////////
  // registers
  reg [7:0] current_tally;
  reg [7:0] wrap_limit;
  reg halt_bit;
  reg overflow_flag;
  reg overflow_irq_enable;
  reg [1:0] source_select;
  reg [3:0] divider_select;
  reg clear_armed;
  reg fixed_meta;
  reg fixed_sync;
  reg fixed_last;
  reg fixed_tick;
  wire tick_rise;
  wire tick_fall;
  wire step;
  reg src_tick;
  reg [7:0] next_tally;
  reg wrap_now;
  reg next_flag;
  reg next_armed;
  wire access;
  wire wr;
  wire rd;
  wire mapped;
  //////////////////////////////////////////////////////////////////////
  // source selection
  mut_edge_sync u_edge (
    .clock(clock),
    .rst_n(rst_n),
    .pin(external_tick_pin),
    .rise(tick_rise),
    .fall(tick_fall)
  );
  // stages follow the pin through reset, so no false edge after it
  always @(posedge clock) begin
    fixed_meta <= fixed_rate_clock;
    fixed_sync <= fixed_meta;
    fixed_last <= fixed_sync;
  end
  always @(posedge clock) begin
    if (!rst_n) begin
      fixed_tick <= 1'b0;
    end else begin
      fixed_tick <= fixed_sync & ~fixed_last;
    end
  end
  always @* begin
    case (source_select)
      `MUT_SRC_BUS: src_tick = 1'b1;
      `MUT_SRC_FIXED: src_tick = fixed_tick;
      `MUT_SRC_FALL: src_tick = tick_fall;
      `MUT_SRC_RISE: src_tick = tick_rise;
      default: src_tick = 1'b0;
    endcase
  end
  mut_prescaler u_pre (
    .clock(clock),
    .rst_n(rst_n),
    .src_tick(src_tick),
    .divider_select(divider_select),
    .step(step)
  );
  //////////////////////////////////////////////////////////////////////
  // apb decode, one wait-free access phase
  assign access = psel & penable;
  assign wr = access & pwrite;
  assign rd = access & ~pwrite;
  assign mapped = (paddr == `MUT_ADDR_CTRL) || (paddr == `MUT_ADDR_CLK) ||
    (paddr == `MUT_ADDR_TALLY) || (paddr == `MUT_ADDR_LIMIT);
  //////////////////////////////////////////////////////////////////////
  // counter and flag
  always @* begin
    next_tally = current_tally;
    wrap_now = 1'b0;
    if (!halt_bit && step) begin
      if (wrap_limit != `MUT_ZERO8 &&
          current_tally == wrap_limit) begin
        next_tally = `MUT_ZERO8;
        wrap_now = 1'b1;
      end else if (wrap_limit == `MUT_ZERO8 &&
          current_tally == `MUT_ONES8) begin
        next_tally = `MUT_ZERO8;
        wrap_now = 1'b1;
      end else begin
        next_tally = current_tally + 8'h01;
      end
    end
    next_armed = clear_armed;
    next_flag = overflow_flag;
    // arm only when the flag was really returned to software
    if (rd && paddr == `MUT_ADDR_CTRL && prdata[`MUT_BIT_FLAG]) begin
      next_armed = 1'b1;
    end
    if (wr && paddr == `MUT_ADDR_CTRL) begin
      if (pwdata[`MUT_BIT_CLR]) begin
        next_tally = `MUT_ZERO8;
        next_flag = 1'b0;
      end else if (!pwdata[`MUT_BIT_FLAG] && clear_armed) begin
        next_flag = 1'b0;
      end
      next_armed = 1'b0;
    end
    if (wr && paddr == `MUT_ADDR_LIMIT) begin
      next_tally = `MUT_ZERO8;
      next_flag = 1'b0;
      next_armed = 1'b0;
    end
    if (wrap_now) begin
      next_flag = 1'b1;
      next_armed = 1'b0;
    end
  end
  //////////////////////////////////////////////////////////////////////
  // register state
  always @(posedge clock) begin
    if (!rst_n) begin
      current_tally <= `MUT_ZERO8;
      wrap_limit <= `MUT_ZERO8;
      halt_bit <= 1'b1;
      overflow_flag <= 1'b0;
      overflow_irq_enable <= 1'b0;
      source_select <= `MUT_SRC_BUS;
      divider_select <= 4'h0;
      clear_armed <= 1'b0;
      overflow_irq <= 1'b0;
    end else begin
      current_tally <= next_tally;
      overflow_flag <= next_flag;
      clear_armed <= next_armed;
      overflow_irq <= next_flag & overflow_irq_enable;
      if (wr && paddr == `MUT_ADDR_CTRL) begin
        overflow_irq_enable <= pwdata[`MUT_BIT_IEN];
        halt_bit <= pwdata[`MUT_BIT_HALT];
      end
      if (wr && paddr == `MUT_ADDR_CLK) begin
        source_select <= pwdata[`MUT_SRC_MSB:`MUT_SRC_LSB];
        divider_select <= pwdata[`MUT_DIV_MSB:0];
      end
      if (wr && paddr == `MUT_ADDR_LIMIT) begin
        wrap_limit <= pwdata[7:0];
      end
    end
  end
  //////////////////////////////////////////////////////////////////////
  // apb answer
  always @(posedge clock) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          `MUT_ADDR_CTRL: prdata <= {24'h000000, overflow_flag,
            overflow_irq_enable, 1'b0, halt_bit, 4'h0};
          `MUT_ADDR_CLK: prdata <= {24'h000000, 2'h0, source_select,
            divider_select};
          `MUT_ADDR_TALLY: prdata <= {24'h000000, current_tally};
          `MUT_ADDR_LIMIT: prdata <= {24'h000000, wrap_limit};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// >>> test/mut_timer_properties.sv
// port assertions of the modulo up timer
`timescale 1ns/100ps
`default_nettype none
`include "mut_defines.vh"
module mut_timer_properties (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic overflow_irq
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence rd_s;
    pready && !pwrite;
  endsequence
  sequence wr_s;
    pready && pwrite;
  endsequence
  ready_after_setup_a: assert property (setup_s |=> pready)
    else $error("no ready after setup");
  ready_single_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  ready_idle_a: assert property (!psel |=> !pready)
    else $error("ready without request");
  unmapped_error_a: assert property (
    pready && paddr > `MUT_ADDR_LIMIT |-> pslverr && prdata == 32'h0)
    else $error("unmapped not refused");
  mapped_ok_a: assert property (pready && paddr <= `MUT_ADDR_LIMIT
    && paddr[1:0] == 2'h0 |-> !pslverr) else $error("mapped refused");
  upper_zero_a: assert property (rd_s |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  clear_reads_zero_a: assert property (
    rd_s ##0 paddr == `MUT_ADDR_CTRL
    |-> !prdata[`MUT_BIT_CLR] && prdata[3:0] == 4'h0)
    else $error("write-only bit reads one");
  limit_zeroes_a: assert property (wr_s ##0 paddr == `MUT_ADDR_LIMIT
    ##[1:2] setup_s ##0 (paddr == `MUT_ADDR_TALLY && !pwrite)
    |=> prdata[7:0] < 8'h04) else $error("count kept after limit write");
  irq_off_a: assert property (wr_s ##0 paddr == `MUT_ADDR_CTRL
    && (!pwdata[`MUT_BIT_IEN] || pwdata[`MUT_BIT_CLR])
    |-> ##[1:2] !overflow_irq) else $error("irq stays high");
endmodule
bind mut_timer mut_timer_properties chk (.clock, .rst_n, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .overflow_irq);
`default_nettype wire

// >>> test/test_modulo_up_timer_8bit.sv
// self-checking bench of the modulo up timer
`timescale 1ns/100ps
`default_nettype none
`include "mut_defines.vh"
module test_modulo_up_timer_8bit;
  logic clock = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, irq;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, seed = 48961;
  logic pready, pslverr, fixed_rate_clock = 0, external_tick_pin = 0;
  logic [3:0] tk = 0;
  logic [7:0] lim, t;
  logic slv_err;
  int num_errors = 0, check_count = 0, i, s, d;
  always #50 clock = ~clock;
  always @(posedge clock) begin
    tk <= tk + 4'h1;
    fixed_rate_clock <= tk[2];
    external_tick_pin <= tk[3];
  end
  mut_timer dut (.clock, .rst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .fixed_rate_clock,
    .external_tick_pin, .overflow_irq(irq));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [7:0] expect_count(int s, int d, int c);
    int per;
    per = (s == 0) ? 1 : (s == 1) ? 8 : 16;
    return 8'((c / per) >> ((d > 8) ? 8 : d));
  endfunction
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] v);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge clock);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge clock);
      if (pready === 1'b1) break;
    end
    if (pready !== 1'b1) begin
      num_errors++;
      stop_test();
    end
    rd = prdata;
    slv_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rc(input string n, input logic [11:0] a,
      input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask
  task automatic poll_flag();
    int k;
    rd = 32'h0;
    for (k = 0; k < 40 && rd[7] !== 1'b1; k++) begin
      apb(1'b0, `MUT_ADDR_CTRL, 32'h0);
    end
    if (rd[7] !== 1'b1) begin
      num_errors++;
      stop_test();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    apb(1'b1, `MUT_ADDR_TALLY, 32'h55);
    rc("ctrl", `MUT_ADDR_CTRL, 32'h10);
    rc("clk", `MUT_ADDR_CLK, 32'h0);
    rc("tally", `MUT_ADDR_TALLY, 32'h0);
    rc("limit", `MUT_ADDR_LIMIT, 32'h0);
    rc("unmapped", 12'h010, 32'h0);
    chk("slverr", 1, slv_err);
    lim = 8'(rnd() % 12 + 3);
    apb(1'b1, `MUT_ADDR_LIMIT, {24'h0, lim});
    rc("limit", `MUT_ADDR_LIMIT, {24'h0, lim});
    chk("slverr", 0, slv_err);
    apb(1'b1, `MUT_ADDR_CTRL, 32'h0);
    poll_flag();
    chk("flag", 1, rd[7]);
    apb(1'b1, `MUT_ADDR_CTRL, 32'h90);
    apb(1'b0, `MUT_ADDR_TALLY, 0);
    t = rd[7:0];
    chk("in range", 1, t <= lim);
    rc("frozen", `MUT_ADDR_TALLY, {24'h0, t});
    rc("armed", `MUT_ADDR_CTRL, 32'h90);
    apb(1'b1, `MUT_ADDR_CTRL, 32'h10);
    rc("cleared", `MUT_ADDR_CTRL, 32'h10);
    apb(1'b1, `MUT_ADDR_CTRL, 32'h0);
    poll_flag();
    repeat (40) @(posedge clock);
    apb(1'b1, `MUT_ADDR_CTRL, 32'h10);
    rc("kept", `MUT_ADDR_CTRL, 32'h90);
    apb(1'b1, `MUT_ADDR_LIMIT, {24'h0, lim});
    rc("limit cnt", `MUT_ADDR_TALLY, 32'h0);
    rc("limit clr", `MUT_ADDR_CTRL, 32'h10);
    apb(1'b1, `MUT_ADDR_CTRL, 32'h40);
    for (i = 0; i < 200 && irq !== 1'b1; i++) @(negedge clock);
    if (irq !== 1'b1) begin
      num_errors++;
      stop_test();
    end
    chk("irq", 1, irq);
    @(posedge clock);
    apb(1'b1, `MUT_ADDR_CTRL, 32'h30);
    rc("trst", `MUT_ADDR_CTRL, 32'h10);
    rc("trst cnt", `MUT_ADDR_TALLY, 32'h0);
    chk("irq low", 0, irq);
    apb(1'b1, `MUT_ADDR_LIMIT, 32'h0);
    for (i = 0; i < 8; i++) begin
      s = i % 4;
      d = (i == 0 && rnd() % 2 == 0) ? 0 :
        int'(rnd() % ((i < 4) ? 4 : 16));
      apb(1'b1, `MUT_ADDR_CLK, 32'(s * 16 + d));
      apb(1'b1, `MUT_ADDR_CTRL, 32'h20);
      repeat (300) @(posedge clock);
      apb(1'b1, `MUT_ADDR_CTRL, 32'h10);
      apb(1'b0, `MUT_ADDR_TALLY, 0);
      t = rd[7:0] - expect_count(s, d, 302) + 8'h04;
      chk("rate", 1, t <= 8'h08);
    end
    rst_n <= 1'b0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    rc("rst ctrl", `MUT_ADDR_CTRL, 32'h10);
    rc("rst clk", `MUT_ADDR_CLK, 32'h0);
    rc("rst limit", `MUT_ADDR_LIMIT, 32'h0);
    rc("rst tally", `MUT_ADDR_TALLY, 32'h0);
    stop_test();
  end
endmodule
`default_nettype wire
